// >>> dv/rfm_contacts.sv
/* Far-side model: four remote contacts that pull the pins low.
   Assumes pclk from the bench; an open contact leaves its pin high. */
`timescale 1ns/1ps
module rfm_contacts (
   // Clock
   input wire logic pclk,
   // Pins toward the mapper
   output logic [rfm_pkg::NUM_PINS-1:0] pin_n
);
   import rfm_pkg::*;
   initial pin_n = '1;
   // A contact moves just after an edge; others keep their state.
   task automatic set_pin(input int i, input logic v);
      @(posedge pclk);
      pin_n[i] <= v;
   endtask : set_pin
endmodule : rfm_contacts

// >>> dv/rfm_mapper_tb.sv
/* Self-checking bench of the remote input function mapper.
   Assumes short debounce and repeat counts set at the instance. */
`timescale 1ns/1ps
module rfm_mapper_tb;
   import rfm_pkg::*;
   localparam int DEB = 4;
   localparam int REP = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [NUM_PINS-1:0] pin_n;
   rfm_act_s actions, act_or;
   rfm_lvl_s levels;
   int failures, checked, act_cnt;

   rfm_mapper #(.DEBOUNCE_CYCLES(DEB), .REPEAT_CYCLES(REP)) i_rfm_mapper (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .remote_pin_n(pin_n), .actions(actions), .levels(levels));
   rfm_contacts i_rfm_contacts (.pclk(pclk), .pin_n(pin_n));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // Pulses are gathered mid-cycle, away from the edges.
   always @(negedge pclk) begin
      if (actions !== '0) begin
         act_or = act_or | actions;
         act_cnt++;
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h", $time, what, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk(n, 2, "pready after one wait state");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic hold(input int i, input logic v);
      i_rfm_contacts.set_pin(i, v);
      repeat (DEB + 8) @(posedge pclk);
   endtask : hold

   task automatic tap(input int i);
      hold(i, 1'b0);
      hold(i, 1'b1);
   endtask : tap

   function automatic rfm_act_s exp_act(input int c);
      rfm_act_s e;
      e = '0;
      case (c)
         1: e.tare_add = 1'b1;
         2: e.tare_clear = 1'b1;
         17: e.print_net = 1'b1;
         18: e.print_gross = 1'b1;
         19: e.print_tare = 1'b1;
         20, 21, 22, 23: e.print_setpoint[c-20] = 1'b1;
         25: e.latch_reset = 1'b1;
         28: e.ascii_send = 1'b1;
         default: e = '0;
      endcase
      e.pv_reload = (c == 1 || c == 2);
      return e;
   endfunction : exp_act

   function automatic rfm_lvl_s exp_lvl(input int c);
      rfm_lvl_s e;
      e = '0;
      e.display_only_freeze = (c == 8 || c == 9);
      e.display_and_output_freeze = (c == 9);
      e.raw_flash = (c == 10);
      e.virtual_setpoint_enable = (c == 24);
      e.serial_unrounded_select = (c == 26);
      e.bcd_unrounded_select = (c == 27);
      if (c >= 10 && c <= 12) e.display_sel = rfm_disp_e'(c - 7);
      if (c == 13) e.analog_sel = ANALOG_FOLLOW_GROSS;
      if (c == 14) e.analog_sel = ANA_ZERO;
      if (c == 15) e.analog_sel = ANALOG_FOLLOW_PEAK;
      if (c == 16) e.analog_sel = ANALOG_FOLLOW_VALLEY;
      return e;
   endfunction : exp_lvl

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic regs_scn();
      apb(0, PIN_FUNC_OFS, 0);
      chk(rd, 0, "codes after reset");
      apb(0, ACTIVE_OFS, 0);
      chk(rd, 32'h06010907, "factory map");
      apb(0, STATUS_OFS, 0);
      chk(32'(rd[ST_DEFAULT_BIT]), 1, "default flag");
      apb(0, 8'h0c, 0);
      chk(32'(err), 1, "unmapped address");
      apb(1, PIN_FUNC_OFS, 32'h1d);
      apb(0, PIN_FUNC_OFS, 0);
      chk(rd, 0, "code above range");
      apb(1, PIN_FUNC_OFS, 32'h1c);
      apb(0, ACTIVE_OFS, 0);
      chk(rd, 32'h1c, "top code");
      pstrb <= 4'h2;
      apb(1, PIN_FUNC_OFS, 32'h0905);
      pstrb <= 4'hf;
      apb(0, ACTIVE_OFS, 0);
      chk(rd, 32'h091c, "byte enables");
      apb(1, PIN_FUNC_OFS, 0);
   endtask : regs_scn

   task automatic default_scn();
      rfm_disp_e ds[3] = '{DISP_PEAK, DISP_VALLEY, DISP_NORMAL};
      act_cnt = 0;
      i_rfm_contacts.set_pin(2, 1'b0);
      hold(2, 1'b1);
      chk(act_cnt, 0, "short glitch");
      act_or = '0;
      hold(2, 1'b0);
      chk(32'(act_or), 32'(exp_act(1)), "tare");
      hold(2, 1'b1);
      chk(act_cnt, 1, "one pulse per edge");
      hold(1, 1'b0);
      chk(32'(levels), 32'(exp_lvl(9)), "hold");
      hold(1, 1'b1);
      chk(32'(levels), 0, "hold release");
      act_or = '0;
      hold(0, 1'b0);
      tap(2);
      chk(32'(act_or), 32'(exp_act(2)), "tare clear combo");
      hold(0, 1'b1);
      for (int k = 0; k < 3; k++) begin
         tap(3);
         chk(32'(levels.display_sel), 32'(ds[k]), "cycle");
      end
      hold(3, 1'b0);
      hold(0, 1'b0);
      hold(3, 1'b1);
      act_or = '0;
      hold(3, 1'b0);
      chk(32'(act_or.peak_clear), 1, "peak clear combo");
      chk(32'(levels.display_sel), 32'(DISP_PEAK), "view kept");
      hold(0, 1'b1);
      hold(3, 1'b1);
      tap(3);
      tap(3);
   endtask : default_scn

   task automatic view_scn();
      int pins[7] = '{0, 1, 0, 1, 2, 1, 2};
      logic [1:0] pv[7] = '{0, 2, 0, 0, 0, 1, 0};
      rfm_disp_e ds[7] = '{DISP_PEAK, DISP_PEAK, DISP_NORMAL, DISP_NORMAL,
                           DISP_VALLEY, DISP_VALLEY, DISP_NORMAL};
      apb(1, PIN_FUNC_OFS, 32'h00040503);
      for (int k = 0; k < 7; k++) begin
         act_or = '0;
         tap(pins[k]);
         chk(32'(levels.display_sel), 32'(ds[k]), "view");
         chk(32'({act_or.peak_clear, act_or.valley_clear}), 32'(pv[k]),
             "view clear");
      end
   endtask : view_scn

   task automatic code_scn();
      for (int c = 0; c <= 28; c++) begin
         if (c < 3 || c > 7) begin
            apb(1, PIN_FUNC_OFS, 32'h1100 | c);
            act_or = '0;
            act_cnt = 0;
            hold(0, 1'b0);
            chk(32'(levels), 32'(exp_lvl(c)), "level");
            chk(32'(act_or), 32'(exp_act(c)), "action");
            hold(0, 1'b1);
            chk(32'(levels), 0, "released");
            chk(act_cnt, 32'(exp_act(c) != 0), "count");
         end
      end
      apb(1, PIN_FUNC_OFS, 32'h1c);
      act_cnt = 0;
      i_rfm_contacts.set_pin(0, 1'b0);
      repeat (2 * REP) @(posedge pclk);
      chk(act_cnt, 2, "repeat send");
      hold(0, 1'b1);
   endtask : code_scn

   task automatic summarize();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      $display("unexpected at %0t: timeout", $time);
      summarize();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hf;
      failures = 0;
      checked = 0;
      act_cnt = 0;
      act_or = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      regs_scn();
      default_scn();
      view_scn();
      code_scn();
      summarize();
   end
endmodule : rfm_mapper_tb

// >>> pkg/rfm_pkg.sv
/*
 * Constants, types and register map of the remote input function mapper.
 * Assumes a 250 MHz pclk and an APB master with 32-bit data.
 */
package rfm_pkg;

   // ----------------------------------------------------------------
   // Sizes and timing
   // ----------------------------------------------------------------
   localparam int NUM_PINS = 4;
   localparam int CODE_W = 5;
   localparam int FN_VEC_W = 32;
   localparam int ADDR_W = 8;
   localparam int CLK_MHZ = 250;
   localparam int DEBOUNCE_NS = 10000;
   localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
   localparam int REPEAT_MS = 1000;
   localparam int REPEAT_CYC = REPEAT_MS * CLK_MHZ * 1000;

   // ----------------------------------------------------------------
   // Function codes
   // ----------------------------------------------------------------
   localparam logic [CODE_W-1:0] CODE_MAX = 5'h1c;
   localparam int FN_TARE = 1;
   localparam int FN_TARE_RESET = 2;
   localparam int FN_PEAK = 3;
   localparam int FN_VALLEY = 4;
   localparam int FN_PV_CLEAR = 5;
   localparam int FN_PV_CYCLE = 6;
   localparam int FN_RESET = 7;
   localparam int FN_FREEZE_DISP = 8;
   localparam int FN_FREEZE_ALL = 9;
   localparam int FN_SHOW_RAW = 10;
   localparam int FN_SHOW_GROSS = 11;
   localparam int FN_SHOW_TARE = 12;
   localparam int FN_ANALOG_FOLLOW_GROSS = 13;
   localparam int FN_ANA_ZERO = 14;
   localparam int FN_ANALOG_FOLLOW_PEAK = 15;
   localparam int FN_ANALOG_FOLLOW_VALLEY = 16;
   localparam int FN_PRINT_NET = 17;
   localparam int FN_PRINT_GROSS = 18;
   localparam int FN_PRINT_TARE = 19;
   localparam int FN_PRINT_SP1 = 20;
   localparam int FN_VIRT_SP = 24;
   localparam int FN_LATCH_RST = 25;
   localparam int FN_SER_UNROUND = 26;
   localparam int FN_BCD_UNROUND = 27;
   localparam int FN_ASCII = 28;

   // Factory map, pin one in the low field.
   localparam logic [NUM_PINS*CODE_W-1:0] DEFAULT_MAP =
      {5'h06, 5'h01, 5'h09, 5'h07};

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] PIN_FUNC_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] ACTIVE_OFS = 8'h08;
   localparam int FIELD_STRIDE = 8;
   localparam int ST_PIN_LSB = 0;
   localparam int ST_DISP_LSB = 4;
   localparam int ST_ANA_LSB = 8;
   localparam int ST_DEFAULT_BIT = 11;
   localparam int ST_FRZ_DISP_BIT = 12;
   localparam int ST_FRZ_OUT_BIT = 13;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PV_NORMAL, PV_PEAK, PV_VALLEY} rfm_pv_e;
   typedef enum logic [2:0] {
      DISP_NORMAL, DISP_PEAK, DISP_VALLEY, DISP_RAW, DISP_GROSS, DISP_TARE
   } rfm_disp_e;
   typedef enum logic [2:0] {
      ANA_NET, ANALOG_FOLLOW_GROSS, ANALOG_FOLLOW_PEAK, ANALOG_FOLLOW_VALLEY, ANA_ZERO
   } rfm_ana_e;

   // One-cycle action requests.
   typedef struct packed {
      logic tare_add;
      logic tare_clear;
      logic pv_reload;
      logic peak_clear;
      logic valley_clear;
      logic print_net;
      logic print_gross;
      logic print_tare;
      logic [NUM_PINS-1:0] print_setpoint;
      logic latch_reset;
      logic ascii_send;
   } rfm_act_s;

   // Levels that hold while a pin is low, and the latched peak or valley view.
   typedef struct packed {
      logic display_only_freeze;
      logic display_and_output_freeze;
      logic raw_flash;
      logic virtual_setpoint_enable;
      logic serial_unrounded_select;
      logic bcd_unrounded_select;
      rfm_disp_e display_sel;
      rfm_ana_e analog_sel;
   } rfm_lvl_s;

endpackage : rfm_pkg

// >>> verilog/rfm_mapper.sv
/*
 * Remote input function mapper: four remote pins, each debounced and
 * bound to a programmable function, driving action pulses and levels.
 * Assumes an APB master on pclk and asynchronous active-low pins.
 */
`timescale 1ns/1ps

module rfm_mapper #(
   parameter int DEBOUNCE_CYCLES = rfm_pkg::DEBOUNCE_CYC,
   parameter int REPEAT_CYCLES = rfm_pkg::REPEAT_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rfm_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Remote pins, low active against common
   input wire logic [rfm_pkg::NUM_PINS-1:0] remote_pin_n,
   // Function outputs
   output rfm_pkg::rfm_act_s actions,
   output rfm_pkg::rfm_lvl_s levels
);
   import rfm_pkg::*;

   localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);
   localparam int RP_W = $clog2(REPEAT_CYCLES + 1);

   logic [CODE_W-1:0] pin_func_reg [NUM_PINS];
   logic [CODE_W-1:0] code_eff [NUM_PINS];
   logic [NUM_PINS-1:0] sync1_reg;
   logic [NUM_PINS-1:0] sync2_reg;
   logic [NUM_PINS-1:0] pin_db_reg;
   logic [NUM_PINS-1:0] pin_fall;
   logic [FN_VEC_W-1:0] fall_fn;
   logic [FN_VEC_W-1:0] low_fn;
   logic use_default;
   logic reset_held;
   rfm_pv_e pv_reg;
   rfm_pv_e pv_next;
   rfm_act_s act_reg;
   rfm_act_s act_next;
   rfm_lvl_s lvl_reg;
   rfm_lvl_s lvl_next;
   logic [RP_W-1:0] rep_cnt_reg;
   logic rep_done;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic apb_access;
   logic apb_commit;
   logic addr_ok;
   logic [31:0] rd_next;

   // ----------------------------------------------------------------
   // Pin conditioning
   // ----------------------------------------------------------------
   // A contact bounces for far longer than one clock; a new level is
   // accepted only after it stood for the whole debounce window.
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         logic [DB_W-1:0] db_cnt_reg;

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_reg[g] <= 1'b1;
               sync2_reg[g] <= 1'b1;
            end else begin
               sync1_reg[g] <= remote_pin_n[g];
               sync2_reg[g] <= sync1_reg[g];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               db_cnt_reg <= '0;
               pin_db_reg[g] <= 1'b1;
            end else if (sync2_reg[g] == pin_db_reg[g]) begin
               db_cnt_reg <= '0;
            end else if (db_cnt_reg == DB_W'(DEBOUNCE_CYCLES - 1)) begin
               db_cnt_reg <= '0;
               pin_db_reg[g] <= sync2_reg[g];
            end else begin
               db_cnt_reg <= db_cnt_reg + 1'b1;
            end
         end

         // One accepted high-to-low change gives one event.
         assign pin_fall[g] = pin_db_reg[g] & ~sync2_reg[g] &
            (db_cnt_reg == DB_W'(DEBOUNCE_CYCLES - 1));
      end
   endgenerate

   // ----------------------------------------------------------------
   // Code mapping
   // ----------------------------------------------------------------
   always_comb begin
      use_default = 1'b1;
      for (int i = 0; i < NUM_PINS; i++) begin
         if (pin_func_reg[i] != '0) begin
            use_default = 1'b0;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         if (use_default) begin
            code_eff[i] = DEFAULT_MAP[i*CODE_W +: CODE_W];
         end else begin
            code_eff[i] = pin_func_reg[i];
         end
      end
   end

   // Bit n of fall_fn is an edge on some pin bound to code n, bit n of
   // low_fn a pin bound to code n that is held low. Bit 0 is never read,
   // and codes above the legal range land in bits nobody looks at.
   always_comb begin
      fall_fn = '0;
      low_fn = '0;
      for (int i = 0; i < NUM_PINS; i++) begin
         fall_fn[code_eff[i]] = fall_fn[code_eff[i]] | pin_fall[i];
         low_fn[code_eff[i]] = low_fn[code_eff[i]] | ~pin_db_reg[i];
      end
   end

   assign reset_held = low_fn[FN_RESET];

   // ----------------------------------------------------------------
   // Peak and valley view
   // ----------------------------------------------------------------
   always_comb begin
      pv_next = pv_reg;
      if (fall_fn[FN_PV_CYCLE] && !reset_held) begin
         unique case (pv_reg)
            PV_NORMAL: pv_next = PV_PEAK;
            PV_PEAK: pv_next = PV_VALLEY;
            PV_VALLEY: pv_next = PV_NORMAL;
         endcase
      end else if (fall_fn[FN_PEAK]) begin
         pv_next = (pv_reg == PV_PEAK) ? PV_NORMAL : PV_PEAK;
      end else if (fall_fn[FN_VALLEY]) begin
         pv_next = (pv_reg == PV_VALLEY) ? PV_NORMAL : PV_VALLEY;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pv_reg <= PV_NORMAL;
      end else begin
         pv_reg <= pv_next;
      end
   end

   // ----------------------------------------------------------------
   // Repeat timer for the ASCII transmit
   // ----------------------------------------------------------------
   assign rep_done = low_fn[FN_ASCII] &&
      (rep_cnt_reg == RP_W'(REPEAT_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rep_cnt_reg <= '0;
      end else if (!low_fn[FN_ASCII] || fall_fn[FN_ASCII] || rep_done) begin
         rep_cnt_reg <= '0;
      end else begin
         rep_cnt_reg <= rep_cnt_reg + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Actions
   // ----------------------------------------------------------------
   always_comb begin
      logic pv_clr;
      pv_clr = fall_fn[FN_PV_CLEAR] | (fall_fn[FN_PV_CYCLE] & reset_held);
      act_next = '0;
      act_next.tare_add = fall_fn[FN_TARE] & ~reset_held;
      act_next.tare_clear = fall_fn[FN_TARE_RESET] |
         (fall_fn[FN_TARE] & reset_held);
      act_next.pv_reload = act_next.tare_add | act_next.tare_clear;
      act_next.peak_clear = pv_clr & (pv_reg == PV_PEAK);
      act_next.valley_clear = pv_clr & (pv_reg == PV_VALLEY);
      act_next.print_net = fall_fn[FN_PRINT_NET];
      act_next.print_gross = fall_fn[FN_PRINT_GROSS];
      act_next.print_tare = fall_fn[FN_PRINT_TARE];
      act_next.print_setpoint =
         fall_fn[FN_PRINT_SP1 +: NUM_PINS];
      act_next.latch_reset = fall_fn[FN_LATCH_RST];
      act_next.ascii_send = fall_fn[FN_ASCII] | rep_done;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_reg <= '0;
      end else begin
         act_reg <= act_next;
      end
   end

   // ----------------------------------------------------------------
   // Levels
   // ----------------------------------------------------------------
   // When several source pins are low together the lower code wins and
   // beats the peak or valley view; a forced zero beats every analog source for safety.
   always_comb begin
      lvl_next.display_only_freeze =
         low_fn[FN_FREEZE_DISP] | low_fn[FN_FREEZE_ALL];
      lvl_next.display_and_output_freeze = low_fn[FN_FREEZE_ALL];
      lvl_next.raw_flash = low_fn[FN_SHOW_RAW];
      lvl_next.virtual_setpoint_enable = low_fn[FN_VIRT_SP];
      lvl_next.serial_unrounded_select = low_fn[FN_SER_UNROUND];
      lvl_next.bcd_unrounded_select = low_fn[FN_BCD_UNROUND];
      if (low_fn[FN_SHOW_RAW]) begin
         lvl_next.display_sel = DISP_RAW;
      end else if (low_fn[FN_SHOW_GROSS]) begin
         lvl_next.display_sel = DISP_GROSS;
      end else if (low_fn[FN_SHOW_TARE]) begin
         lvl_next.display_sel = DISP_TARE;
      end else if (pv_reg == PV_PEAK) begin
         lvl_next.display_sel = DISP_PEAK;
      end else if (pv_reg == PV_VALLEY) begin
         lvl_next.display_sel = DISP_VALLEY;
      end else begin
         lvl_next.display_sel = DISP_NORMAL;
      end
      if (low_fn[FN_ANA_ZERO]) begin
         lvl_next.analog_sel = ANA_ZERO;
      end else if (low_fn[FN_ANALOG_FOLLOW_GROSS]) begin
         lvl_next.analog_sel = ANALOG_FOLLOW_GROSS;
      end else if (low_fn[FN_ANALOG_FOLLOW_PEAK]) begin
         lvl_next.analog_sel = ANALOG_FOLLOW_PEAK;
      end else if (low_fn[FN_ANALOG_FOLLOW_VALLEY]) begin
         lvl_next.analog_sel = ANALOG_FOLLOW_VALLEY;
      end else begin
         lvl_next.analog_sel = ANA_NET;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_reg <= '0;
      end else begin
         lvl_reg <= lvl_next;
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // One wait state keeps prdata, pready and pslverr registered.
   assign apb_access = psel & penable & ~pready_reg;
   assign apb_commit = psel & penable & pready_reg;
   assign addr_ok = (paddr == PIN_FUNC_OFS) || (paddr == STATUS_OFS) ||
      (paddr == ACTIVE_OFS);

   always_comb begin
      rd_next = '0;
      unique case (paddr)
         PIN_FUNC_OFS, ACTIVE_OFS: begin
            for (int i = 0; i < NUM_PINS; i++) begin
               rd_next[i*FIELD_STRIDE +: CODE_W] =
                  (paddr == PIN_FUNC_OFS) ? pin_func_reg[i] : code_eff[i];
            end
         end
         STATUS_OFS: begin
            rd_next[ST_PIN_LSB +: NUM_PINS] = pin_db_reg;
            rd_next[ST_DISP_LSB +: 3] = lvl_reg.display_sel;
            rd_next[ST_ANA_LSB +: 3] = lvl_reg.analog_sel;
            rd_next[ST_DEFAULT_BIT] = use_default;
            rd_next[ST_FRZ_DISP_BIT] = lvl_reg.display_only_freeze;
            rd_next[ST_FRZ_OUT_BIT] = lvl_reg.display_and_output_freeze;
         end
         default: rd_next = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= apb_access;
         pslverr_reg <= apb_access & ~addr_ok;
         if (apb_access && !pwrite) begin
            prdata_reg <= rd_next;
         end
      end
   end

   // An out-of-range code is refused per byte and the old one is kept.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            pin_func_reg[i] <= '0;
         end
      end else if (apb_commit && pwrite && paddr == PIN_FUNC_OFS) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (pstrb[i] &&
                pwdata[i*FIELD_STRIDE +: CODE_W] <= CODE_MAX) begin
               pin_func_reg[i] <= pwdata[i*FIELD_STRIDE +: CODE_W];
            end
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign actions = act_reg;
   assign levels = lvl_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_edge_single_pulse: assert property (
      act_reg.tare_add |=> !act_reg.tare_add)
      else $error("tare request longer than one cycle");

   a_level_follows_pin: assert property (
      lvl_reg.display_only_freeze |-> $past(pin_db_reg != '1))
      else $error("freeze without a low pin");

   a_codes_legal: assert property (
      pin_func_reg[0] <= CODE_MAX && pin_func_reg[1] <= CODE_MAX &&
      pin_func_reg[2] <= CODE_MAX && pin_func_reg[3] <= CODE_MAX)
      else $error("stored function code out of range");

   a_default_map: assert property (
      (pin_func_reg[0] == '0 && pin_func_reg[1] == '0 &&
       pin_func_reg[2] == '0 && pin_func_reg[3] == '0) |->
      code_eff[0] == DEFAULT_MAP[0 +: CODE_W] &&
      code_eff[3] == DEFAULT_MAP[3*CODE_W +: CODE_W])
      else $error("factory map not applied");

   a_tare_reloads_pv: assert property (
      (fall_fn[FN_TARE] || fall_fn[FN_TARE_RESET]) |=> act_reg.pv_reload)
      else $error("tare without peak and valley reload");

   a_pv_cycle_order: assert property (
      (pv_reg == PV_PEAK && fall_fn[FN_PV_CYCLE] && !reset_held) |=>
      pv_reg == PV_VALLEY)
      else $error("peak view did not advance to valley");

   a_ana_zero_wins: assert property (
      low_fn[FN_ANA_ZERO] |=> lvl_reg.analog_sel == ANA_ZERO)
      else $error("analog zero not forced");

   a_reset_combo: assert property (
      (fall_fn[FN_TARE] && reset_held) |=>
      act_reg.tare_clear && !act_reg.tare_add)
      else $error("reset with tare did not clear tare");

   a_debounce_hold: assert property (
      $fell(pin_db_reg[0]) |-> $past(sync2_reg[0]) == 1'b0)
      else $error("debounced level changed without stable input");

   a_apb_one_wait: assert property (
      (psel && penable && !pready_reg) |=> pready_reg)
      else $error("apb answer not after one wait state");

   c_tare_event: cover property (act_reg.tare_add);
   c_pv_to_valley: cover property (pv_reg == PV_VALLEY);
   c_ascii_repeat: cover property (rep_done);
   c_hold_all: cover property (lvl_reg.display_and_output_freeze);

endmodule : rfm_mapper
